/* logic/dio_ports.sv */
// memory-mapped digital port block: two 4-bit I/O, one input, one single-bit
`timescale 1ns/1ps
module dio_ports (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic MEM_STB,
    input wire dio_pkg::dio_op_type MEM_OP,
    input wire dio_pkg::dio_amode_type MEM_AMODE,
    input wire logic [11:0] MEM_ADDR,
    input wire logic [1:0] MEM_BIT,
    input wire logic [7:0] MEM_WDATA,
    input wire logic BANK_ENABLE_FLAG,
    input wire logic [3:0] BANK_SELECT_VALUE,
    input wire logic [3:0] INDEX_L,
    output logic [7:0] MEM_RDATA,
    output logic MEM_DONE,
    output logic MEM_HIT,
    output logic MEM_ERR,
    input wire logic [3:0] IO_GROUP_A_IN,
    output logic [3:0] IO_GROUP_A_OUT,
    output logic [3:0] IO_GROUP_A_OE_N,
    output logic [3:0] IO_GROUP_A_PULLUP,
    input wire logic [3:0] IO_GROUP_B_IN,
    output logic [3:0] IO_GROUP_B_OUT,
    output logic [3:0] IO_GROUP_B_OE_N,
    output logic [3:0] IO_GROUP_B_PULLUP,
    input wire logic [3:0] INPUT_GROUP_C_IN,
    input wire logic SINGLE_IO_IN,
    output logic SINGLE_IO_OUT,
    output logic SINGLE_IO_OE_N,
    output logic SINGLE_IO_PULLUP,
    output logic EXTERNAL_IRQ_INPUT
);
    logic [11:0] eff_addr;
    logic [1:0] bit_idx;
    logic bank_ok;
    logic [7:0] direction_group_a;
    logic [7:0] direction_group_c;
    logic [7:0] pullup_select_a;
    logic [7:0] pullup_select_b;
    logic [3:0] rd_a;
    logic [3:0] rd_b;
    logic [0:0] rd_s;
    logic [3:0] latch_a;
    logic [3:0] latch_b;
    logic [0:0] latch_s;
    logic [0:0] s_out;
    logic [0:0] s_oe_n;
    logic [0:0] s_pull;
    logic hit_a;
    logic hit_b;
    logic hit_c;
    logic hit_s;
    logic hit_dir_a;
    logic hit_dir_c;
    logic hit_pu_a;
    logic hit_pu_b;
    logic any_port;
    logic any_reg8;
    logic is_nib;
    logic is_byte;
    logic is_bit;
    logic is_bit_wr;
    logic is_nib_wr;
    logic legal;
    logic [3:0] cur;
    logic [3:0] next_val;
    logic [3:0] bit_wr_val;
    logic bit_new;
    logic port_wr;
    logic [7:0] next_rdata;
    logic wr_a;
    logic wr_b;
    logic wr_s;

    dio_addr_map u_map (
        .amode(MEM_AMODE),
        .addr(MEM_ADDR),
        .bit_in(MEM_BIT),
        .bank_enable_flag(BANK_ENABLE_FLAG),
        .bank_select_value(BANK_SELECT_VALUE),
        .index_l(INDEX_L),
        .eff_addr(eff_addr),
        .bit_idx(bit_idx),
        .bank_ok(bank_ok)
    );

    // address decode over the port page
    assign hit_a = (eff_addr == dio_pkg::ADDR_IO_A);
    assign hit_b = (eff_addr == dio_pkg::ADDR_IO_B);
    assign hit_c = (eff_addr == dio_pkg::ADDR_IN_C);
    assign hit_s = (eff_addr == dio_pkg::ADDR_SINGLE);
    assign hit_dir_a = (eff_addr == dio_pkg::ADDR_DIR_A);
    assign hit_dir_c = (eff_addr == dio_pkg::ADDR_DIR_C);
    assign hit_pu_a = (eff_addr == dio_pkg::ADDR_PU_A);
    assign hit_pu_b = (eff_addr == dio_pkg::ADDR_PU_B);
    assign any_port = hit_a | hit_b | hit_c | hit_s;
    assign any_reg8 = hit_dir_a | hit_dir_c | hit_pu_a | hit_pu_b;

    // operation classes
    assign is_nib = (MEM_OP == dio_pkg::OP_READ4) |
                    (MEM_OP == dio_pkg::OP_WRITE4) |
                    (MEM_OP == dio_pkg::OP_XCH4) |
                    (MEM_OP == dio_pkg::OP_INCS4);
    assign is_nib_wr = is_nib & (MEM_OP != dio_pkg::OP_READ4);
    assign is_byte = (MEM_OP == dio_pkg::OP_READ8) |
                     (MEM_OP == dio_pkg::OP_WRITE8);
    assign is_bit_wr = (MEM_OP == dio_pkg::OP_BIT_SET) |
                       (MEM_OP == dio_pkg::OP_BIT_CLR) |
                       (MEM_OP == dio_pkg::OP_BIT_MOV) |
                       (MEM_OP == dio_pkg::OP_BIT_TSTCLR);
    assign is_bit = is_bit_wr | (MEM_OP == dio_pkg::OP_BIT_TEST);

    // legality of the access against the target
    always_comb begin
        legal = 1'b0;
        if (!bank_ok) begin
            // prohibited bank setting reaches nothing
            legal = 1'b0;
        end else if (is_byte) begin
            legal = any_reg8;
        end else if (is_nib) begin
            // input-only port takes no write at all
            legal = hit_a | hit_b | hit_s | (hit_c & ~is_nib_wr);
        end else if (is_bit) begin
            // single-bit port has only bit 0 wired
            legal = ((hit_a | hit_b) | (hit_s & (bit_idx == 2'h0)) |
                     (hit_c & ~is_bit_wr)) &
                    (MEM_AMODE != dio_pkg::AM_BANKED);
        end
    end

    // readback of the addressed port, bits above narrow ports read zero
    always_comb begin
        cur = 4'h0;
        if (hit_a) begin
            cur = rd_a;
        end else if (hit_b) begin
            cur = rd_b;
        end else if (hit_c) begin
            cur = INPUT_GROUP_C_IN;
        end else if (hit_s) begin
            cur = {3'h0, rd_s};
        end
    end

    // new bit value per bit operation
    always_comb begin
        bit_new = 1'b0;
        unique case (MEM_OP)
            dio_pkg::OP_BIT_SET: bit_new = 1'b1;
            dio_pkg::OP_BIT_MOV: bit_new = MEM_WDATA[0];
            default: bit_new = 1'b0;
        endcase
    end

    // read-modify-write: in input mode the other bits pick up pin levels
    always_comb begin
        bit_wr_val = cur;
        bit_wr_val[bit_idx] = bit_new;
    end

    // value written back to the target latch
    always_comb begin
        next_val = cur;
        unique case (MEM_OP)
            dio_pkg::OP_WRITE4: next_val = MEM_WDATA[3:0];
            dio_pkg::OP_XCH4: next_val = MEM_WDATA[3:0];
            dio_pkg::OP_INCS4: next_val = cur + dio_pkg::INC_STEP;
            dio_pkg::OP_BIT_SET,
            dio_pkg::OP_BIT_CLR,
            dio_pkg::OP_BIT_MOV,
            dio_pkg::OP_BIT_TSTCLR: next_val = bit_wr_val;
            default: next_val = cur;
        endcase
    end

    assign port_wr = MEM_STB & legal & (is_nib_wr | is_bit_wr);
    assign wr_a = port_wr & hit_a;
    assign wr_b = port_wr & hit_b;
    assign wr_s = port_wr & hit_s;

    // read data presented one cycle after the strobe
    always_comb begin
        next_rdata = 8'h00;
        unique case (MEM_OP)
            dio_pkg::OP_READ4,
            dio_pkg::OP_XCH4: next_rdata = {4'h0, cur};
            dio_pkg::OP_INCS4: next_rdata = {4'h0, next_val};
            dio_pkg::OP_BIT_TEST,
            dio_pkg::OP_BIT_TSTCLR: next_rdata = {7'h00, cur[bit_idx]};
            dio_pkg::OP_READ8: begin
                if (hit_dir_a) begin
                    next_rdata = direction_group_a;
                end else if (hit_dir_c) begin
                    next_rdata = direction_group_c;
                end else if (hit_pu_a) begin
                    next_rdata = pullup_select_a;
                end else if (hit_pu_b) begin
                    next_rdata = pullup_select_b;
                end
            end
            default: next_rdata = 8'h00;
        endcase
    end

    dio_io_port #(.W(4)) u_io_a (
        .clk(CLK),
        .srst(SRST),
        .pin_in(IO_GROUP_A_IN),
        .dir(direction_group_a[dio_pkg::DIR_A_IO_A_LSB +: 4]),
        .pull_sel(pullup_select_a[dio_pkg::PU_A_IO_A_BIT]),
        .wr_en(wr_a),
        .wr_data(next_val),
        .latch_q(latch_a),
        .read_val(rd_a),
        .pin_out(IO_GROUP_A_OUT),
        .pin_oe_n(IO_GROUP_A_OE_N),
        .pull_en(IO_GROUP_A_PULLUP)
    );

    dio_io_port #(.W(4)) u_io_b (
        .clk(CLK),
        .srst(SRST),
        .pin_in(IO_GROUP_B_IN),
        .dir(direction_group_a[dio_pkg::DIR_A_IO_B_LSB +: 4]),
        .pull_sel(pullup_select_a[dio_pkg::PU_A_IO_B_BIT]),
        .wr_en(wr_b),
        .wr_data(next_val),
        .latch_q(latch_b),
        .read_val(rd_b),
        .pin_out(IO_GROUP_B_OUT),
        .pin_oe_n(IO_GROUP_B_OE_N),
        .pull_en(IO_GROUP_B_PULLUP)
    );

    dio_io_port #(.W(1)) u_single (
        .clk(CLK),
        .srst(SRST),
        .pin_in(SINGLE_IO_IN),
        .dir(direction_group_c[dio_pkg::DIR_C_SINGLE_BIT]),
        .pull_sel(pullup_select_b[dio_pkg::PU_B_SINGLE_BIT]),
        .wr_en(wr_s),
        .wr_data(next_val[0]),
        .latch_q(latch_s),
        .read_val(rd_s),
        .pin_out(s_out),
        .pin_oe_n(s_oe_n),
        .pull_en(s_pull)
    );

    assign SINGLE_IO_OUT = s_out[0];
    assign SINGLE_IO_OE_N = s_oe_n[0];
    assign SINGLE_IO_PULLUP = s_pull[0];

    // direction registers, byte writes only
    always_ff @(posedge CLK) begin
        if (SRST) begin
            direction_group_a <= dio_pkg::DIR_RESET;
            direction_group_c <= dio_pkg::DIR_RESET;
        end else if (MEM_STB && legal && MEM_OP == dio_pkg::OP_WRITE8) begin
            if (hit_dir_a) begin
                direction_group_a <= MEM_WDATA;
            end
            if (hit_dir_c) begin
                direction_group_c <= MEM_WDATA;
            end
        end
    end

    // pull-up select registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pullup_select_a <= dio_pkg::PU_RESET;
            pullup_select_b <= dio_pkg::PU_RESET;
        end else if (MEM_STB && legal && MEM_OP == dio_pkg::OP_WRITE8) begin
            if (hit_pu_a) begin
                pullup_select_a <= MEM_WDATA;
            end
            if (hit_pu_b) begin
                pullup_select_b <= MEM_WDATA;
            end
        end
    end

    // answer to the core: data, done, hit and refusal
    always_ff @(posedge CLK) begin
        if (SRST) begin
            MEM_RDATA <= 8'h00;
            MEM_DONE <= 1'b0;
            MEM_HIT <= 1'b0;
            MEM_ERR <= 1'b0;
        end else begin
            MEM_DONE <= MEM_STB;
            MEM_HIT <= MEM_STB & (any_port | any_reg8);
            MEM_ERR <= MEM_STB & (any_port | any_reg8) & ~legal;
            if (MEM_STB) begin
                // refused accesses read back zero
                MEM_RDATA <= legal ? next_rdata : 8'h00;
            end
        end
    end

    // shared interrupt pin level; the noise filter lives with the
    // interrupt controller, so only the raw level is handed on
    always_ff @(posedge CLK) begin
        if (SRST) begin
            EXTERNAL_IRQ_INPUT <= 1'b0;
        end else begin
            EXTERNAL_IRQ_INPUT <= IO_GROUP_B_IN[dio_pkg::IRQ_PIN_BIT];
        end
    end
endmodule // dio_ports

/* shared/dio_pkg.sv */
// shared constants and types for the memory-mapped digital port block
package dio_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_IO_A = 12'hFF3;
    localparam logic [11:0] ADDR_IO_B = 12'hFF6;
    localparam logic [11:0] ADDR_IN_C = 12'hFF7;
    localparam logic [11:0] ADDR_SINGLE = 12'hFF8;
    localparam logic [11:0] ADDR_DIR_A = 12'hFE8;
    localparam logic [11:0] ADDR_DIR_C = 12'hFEC;
    localparam logic [11:0] ADDR_PU_A = 12'hFDC;
    localparam logic [11:0] ADDR_PU_B = 12'hFDE;
    localparam logic [3:0] BANK_LOW = 4'h0;
    localparam logic [3:0] BANK_HIGH = 4'hF;
    localparam int DIR_A_IO_A_LSB = 0;
    localparam int DIR_A_IO_B_LSB = 4;
    localparam int DIR_C_SINGLE_BIT = 0;
    localparam int PU_A_IO_A_BIT = 3;
    localparam int PU_A_IO_B_BIT = 6;
    localparam int PU_B_SINGLE_BIT = 0;
    localparam int IRQ_PIN_BIT = 1;
    localparam logic [3:0] LATCH_RESET = 4'h0;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] PU_RESET = 8'h00;
    localparam logic [3:0] INC_STEP = 4'h1;

    typedef enum logic [3:0] {
        OP_READ4, OP_WRITE4, OP_XCH4, OP_INCS4,
        OP_READ8, OP_WRITE8,
        OP_BIT_TEST, OP_BIT_SET, OP_BIT_CLR, OP_BIT_MOV, OP_BIT_TSTCLR
    } dio_op_type;

    typedef enum logic [1:0] {
        AM_BANKED, AM_FMEM_BIT, AM_PMEM_L
    } dio_amode_type;
endpackage

/* logic/dio_addr_map.sv */
// effective data-memory address and bit position for each addressing mode
`timescale 1ns/1ps
module dio_addr_map (
    input wire dio_pkg::dio_amode_type amode,
    input wire logic [11:0] addr,
    input wire logic [1:0] bit_in,
    input wire logic bank_enable_flag,
    input wire logic [3:0] bank_select_value,
    input wire logic [3:0] index_l,
    output logic [11:0] eff_addr,
    output logic [1:0] bit_idx,
    output logic bank_ok
);
    always_comb begin
        eff_addr = addr;
        bit_idx = bit_in;
        bank_ok = 1'b1;
        unique case (amode)
            dio_pkg::AM_BANKED: begin
                // flag clear: low half to bank 0, upper half to the port page
                if (bank_enable_flag) begin
                    eff_addr = {bank_select_value, addr[7:0]};
                    bank_ok = (bank_select_value == dio_pkg::BANK_LOW) ||
                              (bank_select_value == dio_pkg::BANK_HIGH);
                end else begin
                    eff_addr = {(addr[7] ? dio_pkg::BANK_HIGH : dio_pkg::BANK_LOW),
                                addr[7:0]};
                end
            end
            dio_pkg::AM_FMEM_BIT: begin
                eff_addr = {dio_pkg::BANK_HIGH, addr[7:0]};
            end
            dio_pkg::AM_PMEM_L: begin
                eff_addr = {dio_pkg::BANK_HIGH, addr[7:2], index_l[3:2]};
                bit_idx = index_l[1:0];
            end
            default: begin
                bank_ok = 1'b0;
            end
        endcase
    end
endmodule // dio_addr_map

/* logic/dio_io_port.sv */
// one bidirectional port: output latch, driver enable, readback, pull-up
`timescale 1ns/1ps
module dio_io_port #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] pin_in,
    input wire logic [W-1:0] dir,
    input wire logic pull_sel,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    output logic [W-1:0] latch_q,
    output logic [W-1:0] read_val,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe_n,
    output logic [W-1:0] pull_en
);
    if (W < 1 || W > 4) begin : g_bad_width
        $error("dio_io_port width must be 1 to 4");
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            latch_q <= W'(dio_pkg::LATCH_RESET);
        end else if (wr_en) begin
            latch_q <= wr_data;
        end
    end

    for (genvar i = 0; i < W; i++) begin : g_pin
        // input pins show the pad, output pins the latch
        assign read_val[i] = dir[i] ? latch_q[i] : pin_in[i];
        assign pin_oe_n[i] = ~dir[i];
        // a pull-up fighting our own driver only wastes current
        assign pull_en[i] = pull_sel & ~dir[i];
    end
    assign pin_out = latch_q;
endmodule // dio_io_port

/* verification/dio_pin_model.sv */
// board-side pin circuitry: device driver, external drive, pull-up, floating level
`timescale 1ns/1ps
module dio_pin_model #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic [W-1:0] dev_out,
    input wire logic [W-1:0] dev_oe_n,
    input wire logic [W-1:0] dev_pullup,
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] pin
);
    logic [W-1:0] drift = '0;
    // a floating pin keeps changing so a stale level never reads back by luck
    always @(posedge clk) begin
        drift <= ~drift;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!dev_oe_n[i]) begin
                pin[i] = dev_out[i];
            end else if (ext_en[i]) begin
                pin[i] = ext_val[i];
            end else if (dev_pullup[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = drift[i];
            end
        end
    end
endmodule // dio_pin_model

/* verification/dio_ports_chk.sv */
// timing checker for the digital port block, bound to its top ports
`timescale 1ns/1ps
module dio_ports_chk (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic MEM_STB,
    input wire dio_pkg::dio_op_type MEM_OP,
    input wire dio_pkg::dio_amode_type MEM_AMODE,
    input wire logic [11:0] MEM_ADDR,
    input wire logic [7:0] MEM_WDATA,
    input wire logic BANK_ENABLE_FLAG,
    input wire logic [7:0] MEM_RDATA,
    input wire logic MEM_DONE,
    input wire logic MEM_HIT,
    input wire logic MEM_ERR,
    input wire logic [3:0] IO_GROUP_A_IN,
    input wire logic [3:0] IO_GROUP_A_OUT,
    input wire logic [3:0] IO_GROUP_A_OE_N,
    input wire logic [3:0] IO_GROUP_A_PULLUP,
    input wire logic [3:0] IO_GROUP_B_IN,
    input wire logic [3:0] IO_GROUP_B_OE_N,
    input wire logic SINGLE_IO_OE_N,
    input wire logic EXTERNAL_IRQ_INPUT
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    sequence s_port_a(dio_pkg::dio_op_type o);
        MEM_STB && MEM_OP == o && MEM_AMODE == dio_pkg::AM_BANKED
            && MEM_ADDR[7:0] == 8'hF3 && !BANK_ENABLE_FLAG;
    endsequence
    a_done_follows: assert property (MEM_STB |=> MEM_DONE) else $error("no done after strobe");
    a_err_quiet: assert property (MEM_ERR |-> MEM_HIT && MEM_DONE && MEM_RDATA == 8'h00)
        else $error("refusal flags or data wrong");
    a_reset_clears: assert property ($fell(SRST) |-> IO_GROUP_A_OUT == 4'h0
        && IO_GROUP_A_OE_N == 4'hF && IO_GROUP_B_OE_N == 4'hF && SINGLE_IO_OE_N)
        else $error("state not cleared by reset");
    a_dir_cause: assert property (!$stable(IO_GROUP_A_OE_N) |-> $past(SRST)
        || ($past(MEM_STB) && $past(MEM_OP) == dio_pkg::OP_WRITE8))
        else $error("driver enable moved without byte write");
    a_latch_cause: assert property (!$stable(IO_GROUP_A_OUT) |-> $past(SRST)
        || ($past(MEM_STB) && $past(MEM_OP) != dio_pkg::OP_READ4))
        else $error("latch moved without write");
    a_pullup_input: assert property ((IO_GROUP_A_PULLUP & ~IO_GROUP_A_OE_N) == 4'h0)
        else $error("pull-up on an output pin");
    a_irq_copy: assert property (!$past(SRST) |-> EXTERNAL_IRQ_INPUT == $past(IO_GROUP_B_IN[1]))
        else $error("interrupt pin copy wrong");
    a_write_latch: assert property (s_port_a(dio_pkg::OP_WRITE4)
        |=> IO_GROUP_A_OUT == $past(MEM_WDATA[3:0])) else $error("nibble write lost");
    a_read_mix: assert property (s_port_a(dio_pkg::OP_READ4) |=> MEM_RDATA[3:0]
        == (($past(IO_GROUP_A_IN) & $past(IO_GROUP_A_OE_N))
        | ($past(IO_GROUP_A_OUT) & ~$past(IO_GROUP_A_OE_N)))) else $error("readback wrong");
endmodule // dio_ports_chk
bind dio_ports dio_ports_chk i_dio_ports_chk (
    .CLK(CLK), .SRST(SRST), .MEM_STB(MEM_STB), .MEM_OP(MEM_OP), .MEM_AMODE(MEM_AMODE),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .BANK_ENABLE_FLAG(BANK_ENABLE_FLAG),
    .MEM_RDATA(MEM_RDATA), .MEM_DONE(MEM_DONE), .MEM_HIT(MEM_HIT), .MEM_ERR(MEM_ERR),
    .IO_GROUP_A_IN(IO_GROUP_A_IN), .IO_GROUP_A_OUT(IO_GROUP_A_OUT),
    .IO_GROUP_A_OE_N(IO_GROUP_A_OE_N), .IO_GROUP_A_PULLUP(IO_GROUP_A_PULLUP),
    .IO_GROUP_B_IN(IO_GROUP_B_IN), .IO_GROUP_B_OE_N(IO_GROUP_B_OE_N),
    .SINGLE_IO_OE_N(SINGLE_IO_OE_N), .EXTERNAL_IRQ_INPUT(EXTERNAL_IRQ_INPUT)
);

/* verification/dio_ports_tb.sv */
// self-checking bench for the memory-mapped digital port block
`timescale 1ns/1ps
module dio_ports_tb;
    logic clk = 1'b0, srst = 1'b1, stb = 1'b0, bef = 1'b0, s_ext = 1'b0, s_en = 1'b1;
    logic done, hit, err, s_in, s_out, s_oe_n, s_pu, irq;
    dio_pkg::dio_op_type op = dio_pkg::OP_READ4;
    dio_pkg::dio_amode_type am = dio_pkg::AM_BANKED;
    logic [11:0] addr = 12'h000;
    logic [1:0] bt = 2'h0;
    logic [7:0] wd = 8'h00, rdata;
    logic [3:0] bsv = 4'h0, idx = 4'h0, c_in = 4'h9, a_ext = 4'hA, a_en = 4'hF;
    logic [3:0] b_ext = 4'h6, b_en = 4'hF;
    logic [3:0] a_in, a_out, a_oe_n, a_pu, b_in, b_out, b_oe_n, b_pu;
    int err_count = 0, check_count = 0, cycles = 0;
    dio_ports i_dio_ports (
        .CLK(clk), .SRST(srst), .MEM_STB(stb), .MEM_OP(op), .MEM_AMODE(am), .MEM_ADDR(addr),
        .MEM_BIT(bt), .MEM_WDATA(wd), .BANK_ENABLE_FLAG(bef), .BANK_SELECT_VALUE(bsv),
        .INDEX_L(idx), .MEM_RDATA(rdata), .MEM_DONE(done), .MEM_HIT(hit), .MEM_ERR(err),
        .IO_GROUP_A_IN(a_in), .IO_GROUP_A_OUT(a_out), .IO_GROUP_A_OE_N(a_oe_n),
        .IO_GROUP_A_PULLUP(a_pu), .IO_GROUP_B_IN(b_in), .IO_GROUP_B_OUT(b_out),
        .IO_GROUP_B_OE_N(b_oe_n), .IO_GROUP_B_PULLUP(b_pu), .INPUT_GROUP_C_IN(c_in),
        .SINGLE_IO_IN(s_in), .SINGLE_IO_OUT(s_out), .SINGLE_IO_OE_N(s_oe_n),
        .SINGLE_IO_PULLUP(s_pu), .EXTERNAL_IRQ_INPUT(irq)
    );
    dio_pin_model #(.W(4)) i_dio_pin_model_a (.clk(clk), .dev_out(a_out), .dev_oe_n(a_oe_n),
        .dev_pullup(a_pu), .ext_val(a_ext), .ext_en(a_en), .pin(a_in));
    dio_pin_model #(.W(4)) i_dio_pin_model_b (.clk(clk), .dev_out(b_out), .dev_oe_n(b_oe_n),
        .dev_pullup(b_pu), .ext_val(b_ext), .ext_en(b_en), .pin(b_in));
    dio_pin_model #(.W(1)) i_dio_pin_model_s (.clk(clk), .dev_out(s_out), .dev_oe_n(s_oe_n),
        .dev_pullup(s_pu), .ext_val(s_ext), .ext_en(s_en), .pin(s_in));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic wrap_up();
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // run should need under a hundred cycles; ceiling leaves wide margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input dio_pkg::dio_op_type o, input dio_pkg::dio_amode_type m,
            input logic [11:0] ad, input logic [1:0] b, input logic [7:0] d);
        @(posedge clk);
        stb <= 1'b1;
        op <= o;
        am <= m;
        addr <= ad;
        bt <= b;
        wd <= d;
        @(posedge clk);
        stb <= 1'b0;
        #1;
        chk({7'h00, done}, 8'h01);
    endtask
    task automatic w4(input logic [11:0] ad, input logic [3:0] d);
        acc(dio_pkg::OP_WRITE4, dio_pkg::AM_BANKED, ad, 2'h0, {4'h0, d});
    endtask
    task automatic w8(input logic [11:0] ad, input logic [7:0] d);
        acc(dio_pkg::OP_WRITE8, dio_pkg::AM_BANKED, ad, 2'h0, d);
    endtask
    task automatic op4(input dio_pkg::dio_op_type o, input logic [11:0] ad, input logic [3:0] d);
        acc(o, dio_pkg::AM_BANKED, ad, 2'h0, {4'h0, d});
    endtask
    task automatic fbit(input dio_pkg::dio_op_type o, input logic [11:0] ad, input logic [1:0] b,
            input logic d);
        acc(o, dio_pkg::AM_FMEM_BIT, ad, b, {7'h00, d});
    endtask
    task automatic setbank(input logic f, input logic [3:0] s);
        @(posedge clk);
        bef <= f;
        bsv <= s;
    endtask
    task automatic t_reset();
        chk({a_out, b_out}, 8'h00);
        chk({a_oe_n, b_oe_n}, 8'hFF);
        chk({5'h00, s_out, s_oe_n, s_pu}, 8'h02);
        acc(dio_pkg::OP_READ8, dio_pkg::AM_BANKED, dio_pkg::ADDR_DIR_A, 2'h0, 8'h00);
        chk(rdata, 8'h00);
    endtask
    task automatic t_port_a();
        w4(12'h0F3, 4'h5);
        chk({a_out, a_oe_n}, 8'h5F);
        op4(dio_pkg::OP_READ4, 12'h0F3, 4'h0);
        chk(rdata, 8'h0A);
        w8(dio_pkg::ADDR_DIR_A, 8'h0F);
        chk({a_oe_n, a_in}, 8'h05);
        @(posedge clk);
        a_en <= 4'h0;
        op4(dio_pkg::OP_READ4, 12'h0F3, 4'h0);
        chk(rdata, 8'h05);
        w4(12'h0F3, 4'h9);
        chk({4'h0, a_in}, 8'h09);
        op4(dio_pkg::OP_XCH4, 12'h0F3, 4'h3);
        chk({rdata[3:0], a_in}, 8'h93);
        op4(dio_pkg::OP_INCS4, 12'h0F3, 4'h0);
        chk({4'h0, a_in}, 8'h04);
        w4(12'h0F3, 4'hF);
        op4(dio_pkg::OP_INCS4, 12'h0F3, 4'h0);
        chk({4'h0, a_out}, 8'h00);
        op4(dio_pkg::OP_XCH4, 12'h0F6, 4'hC);
        chk({rdata[3:0], b_out}, 8'h6C);
        op4(dio_pkg::OP_INCS4, 12'h0F6, 4'h0);
        chk({b_out, b_oe_n}, 8'h7F);
    endtask
    task automatic t_bits();
        setbank(1'b1, 4'h5);
        fbit(dio_pkg::OP_BIT_SET, 12'hFF3, 2'h2, 1'b0);
        chk({4'h0, a_in}, 8'h04);
        fbit(dio_pkg::OP_BIT_MOV, 12'hFF3, 2'h0, 1'b1);
        chk({4'h0, a_out}, 8'h05);
        fbit(dio_pkg::OP_BIT_TSTCLR, 12'hFF3, 2'h2, 1'b0);
        chk({rdata[3:0], a_out}, 8'h11);
        fbit(dio_pkg::OP_BIT_CLR, 12'hFF3, 2'h0, 1'b0);
        fbit(dio_pkg::OP_BIT_TEST, 12'hFF3, 2'h0, 1'b0);
        chk({rdata[3:0], a_out}, 8'h00);
        @(posedge clk);
        idx <= 4'hB;
        acc(dio_pkg::OP_BIT_SET, dio_pkg::AM_PMEM_L, 12'hFF4, 2'h0, 8'h00);
        chk({3'h0, b_out[3], b_oe_n}, 8'h1F);
        acc(dio_pkg::OP_BIT_TEST, dio_pkg::AM_PMEM_L, 12'hFF4, 2'h0, 8'h00);
        chk(rdata, 8'h00);
        fbit(dio_pkg::OP_BIT_SET, 12'hFF8, 2'h0, 1'b0);
        chk({7'h00, s_out}, 8'h01);
        fbit(dio_pkg::OP_BIT_SET, 12'hFF8, 2'h1, 1'b0);
        chk({6'h00, hit, err}, 8'h03);
    endtask
    task automatic t_refuse();
        // prohibited bank lands off the port page: no hit, latch untouched
        w4(12'hFF3, 4'h7);
        chk({2'h0, hit, err, a_out}, 8'h00);
        setbank(1'b1, 4'hF);
        w4(12'hFF3, 4'h7);
        chk({2'h0, hit, err, a_out}, 8'h27);
        setbank(1'b0, 4'h0);
        w4(12'h0F7, 4'h1);
        chk({6'h00, hit, err}, 8'h03);
        op4(dio_pkg::OP_READ4, 12'h0F7, 4'h0);
        chk(rdata, 8'h09);
        op4(dio_pkg::OP_READ4, 12'h0F0, 4'h0);
        chk({hit, err, rdata[5:0]}, 8'h00);
        acc(dio_pkg::OP_READ8, dio_pkg::AM_BANKED, 12'h0F3, 2'h0, 8'h00);
        chk({6'h00, hit, err}, 8'h03);
    endtask
    task automatic t_pullup();
        w8(dio_pkg::ADDR_PU_A, 8'h48);
        chk({a_pu, b_pu}, 8'h0F);
        @(posedge clk);
        b_en <= 4'h0;
        op4(dio_pkg::OP_READ4, 12'h0F6, 4'h0);
        chk(rdata, 8'h0F);
        w8(dio_pkg::ADDR_PU_B, 8'h01);
        chk({7'h00, s_pu}, 8'h01);
        w8(dio_pkg::ADDR_DIR_C, 8'h01);
        chk({6'h00, s_oe_n, s_pu}, 8'h00);
        op4(dio_pkg::OP_READ4, 12'h0F8, 4'h0);
        chk(rdata, 8'h01);
        @(posedge clk);
        b_en <= 4'hF;
        // pin 1 was high until now, so a stuck copy shows
        b_ext <= 4'h5;
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h00);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_port_a();
        t_bits();
        t_refuse();
        t_pullup();
        wrap_up();
    end
endmodule // dio_ports_tb
